// file: hw/iptr_pkg.sv
// shared constants and types of the indirect pointer addressing unit
package iptr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PTR_W = 12;
  localparam int BYTE_W = 8;
  localparam int NUM_PAIRS = 3;
  localparam int PAIR_SEL_W = 2;
  localparam int HI_USED_W = PTR_W - BYTE_W;

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [PTR_W-1:0] PTR_STEP = 12'h001;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [HI_USED_W-1:0] HI_UNUSED_ZERO = 4'h0;

  // virtual operand codes in the special function space: for each pair,
  // plain at its base and the four other operands just below it
  localparam logic [PTR_W-1:0] VOP_BASE0 = 12'hFEF;
  localparam logic [PTR_W-1:0] VOP_BASE1 = 12'hFE7;
  localparam logic [PTR_W-1:0] VOP_BASE2 = 12'hFDF;
  localparam logic [PTR_W-1:0] VOP_SPAN = 12'h004;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_PLAIN   = 5'h01,
    MODE_POST_DECREMENT_OPERAND = 5'h02,
    MODE_POST_INCREMENT_OPERAND = 5'h04,
    MODE_PRE_INCREMENT_OPERAND  = 5'h08,
    MODE_OFFSET  = 5'h10
  } iptr_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ISSUE = 3'h2,
    ST_WAIT  = 3'h4
  } iptr_state_t;

  // indirect access request from instruction execution
  typedef struct packed {
    logic valid;
    logic [PAIR_SEL_W-1:0] pair;
    iptr_mode_t mode;
    logic write;
    logic [BYTE_W-1:0] wdata;
    logic [BYTE_W-1:0] wreg;
  } iptr_req_t;

  // direct write of one pointer byte
  typedef struct packed {
    logic valid;
    logic [PAIR_SEL_W-1:0] pair;
    logic high;
    logic [BYTE_W-1:0] data;
  } iptr_ptrwr_t;

  // data RAM port
  typedef struct packed {
    logic en;
    logic we;
    logic [PTR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } iptr_ram_t;

  // answer to an indirect access
  typedef struct packed {
    logic valid;
    logic [BYTE_W-1:0] data;
  } iptr_rsp_t;

  // true when an address lands on any virtual operand code
  function automatic logic isVirtual(input logic [PTR_W-1:0] a);
    isVirtual = ((a <= VOP_BASE0) && (a >= VOP_BASE0 - VOP_SPAN)) ||
                ((a <= VOP_BASE1) && (a >= VOP_BASE1 - VOP_SPAN)) ||
                ((a <= VOP_BASE2) && (a >= VOP_BASE2 - VOP_SPAN));
  endfunction

endpackage

// file: hw/iptr_pair.sv
// one pointer pair: low byte plus four used bits of the high byte
`timescale 1ns/1ps
module iptr_pair
  import iptr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // direct byte write
  input wire logic byteWe,
  input wire logic byteHigh,
  input wire logic [BYTE_W-1:0] byteData,
  // automatic step
  input wire logic stepEn,
  input wire logic stepDown,
  // pointer value
  output logic [PTR_W-1:0] ptr_q
);

  logic [PTR_W-1:0] ptr_d;

  always_comb begin
    ptr_d = ptr_q;
    if (byteWe) begin
      if (byteHigh) begin
        ptr_d = {byteData[HI_USED_W-1:0], ptr_q[BYTE_W-1:0]};
      end else begin
        ptr_d = {ptr_q[PTR_W-1:BYTE_W], byteData};
      end
    end else if (stepEn) begin
      // whole-pair step, carry and borrow cross bytes, wraps at 12 bits
      if (stepDown) begin
        ptr_d = ptr_q - PTR_STEP;
      end else begin
        ptr_d = ptr_q + PTR_STEP;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_q <= PTR_RESET;
    end else begin
      ptr_q <= ptr_d;
    end
  end

endmodule

// file: hw/iptr_agen.sv
// target address and pointer step for one operand mode
`timescale 1ns/1ps
module iptr_agen
  import iptr_pkg::*;
(
  // operand
  input iptr_mode_t mode,
  input wire logic [PTR_W-1:0] ptr,
  input wire logic [BYTE_W-1:0] wreg,
  // result
  output logic [PTR_W-1:0] target,
  output logic stepEn,
  output logic stepDown
);

  logic [PTR_W-1:0] offsetExt;

  // working register taken as signed, sign-extended to pointer width
  assign offsetExt = {{HI_USED_W{wreg[BYTE_W-1]}}, wreg};

  always_comb begin
    target = ptr;
    stepEn = 1'b0;
    stepDown = 1'b0;
    case (mode)
      MODE_PLAIN: begin
        target = ptr;
      end
      MODE_POST_DECREMENT_OPERAND: begin
        target = ptr;
        stepEn = 1'b1;
        stepDown = 1'b1;
      end
      MODE_POST_INCREMENT_OPERAND: begin
        target = ptr;
        stepEn = 1'b1;
      end
      MODE_PRE_INCREMENT_OPERAND: begin
        target = ptr + PTR_STEP;
        stepEn = 1'b1;
      end
      MODE_OFFSET: begin
        target = ptr + offsetExt;
      end
      default: begin
        target = ptr;
      end
    endcase
  end

endmodule

// file: hw/iptr_unit.sv
// indirect pointer addressing unit between instruction execution and RAM
`timescale 1ns/1ps
// Function
// - three pointer pairs of two bytes; high byte uses four bits, 12-bit
// - plain operand accesses the pointed location, pointer unchanged
// - bank select and access-bank bit play no part in the address
// - operand codes have no storage; access redirects to the pointer
// - operands are not reachable through another pointer
// - post-decrement uses the pointer, then lowers the pair by one
// - post-increment uses the pointer, then raises the pair by one
// - pre-increment raises the pair by one, then uses the new value
// - offset operand adds signed working register to the pointer
// - offset and plain leave pointer and working register alone
// - steps act on the whole pair, carry and borrow cross bytes
// - pointer steps never change arithmetic status flags
module iptr_unit
  import iptr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // indirect access from instruction execution
  input iptr_req_t req,
  output logic reqReady_q,
  output iptr_rsp_t rsp_q,
  // direct pointer byte writes
  input iptr_ptrwr_t ptrWr,
  // pointer values for readback
  output logic [NUM_PAIRS-1:0][PTR_W-1:0] ptrView_q,
  // data RAM, read data one cycle after a read enable
  output iptr_ram_t ram_q,
  input wire logic [BYTE_W-1:0] ramRdata
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iptr_state_t state_q;
  iptr_state_t state_d;
  logic accept;
  logic virtTarget_q;
  logic isWrite_q;

  // ----------------------------------------------------------------
  // pointer pairs
  // ----------------------------------------------------------------
  logic [PTR_W-1:0] selPtr;
  logic [PTR_W-1:0] target;
  logic stepEn;
  logic stepDown;

  assign accept = req.valid && reqReady_q;

  always_comb begin
    selPtr = ptrView_q[0];
    if (req.pair == 2'h1) begin
      selPtr = ptrView_q[1];
    end else if (req.pair == 2'h2) begin
      selPtr = ptrView_q[2];
    end
  end

  iptr_agen agen (
    .mode(req.mode),
    .ptr(selPtr),
    .wreg(req.wreg),
    .target(target),
    .stepEn(stepEn),
    .stepDown(stepDown)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
      logic hitWr;
      logic hitStep;
      assign hitWr = ptrWr.valid &&
                     (ptrWr.pair == PAIR_SEL_W'(gi));
      // step applied on the accepting edge; no flag is touched
      assign hitStep = accept && stepEn &&
                       (req.pair == PAIR_SEL_W'(gi));
      iptr_pair pair (
        .clk(clk),
        .reset(reset),
        .byteWe(hitWr),
        .byteHigh(ptrWr.high),
        .byteData(ptrWr.data),
        .stepEn(hitStep),
        .stepDown(stepDown),
        .ptr_q(ptrView_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (!isWrite_q && !virtTarget_q) begin
          state_d = ST_WAIT;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_WAIT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reqReady_q <= 1'b1;
    end else begin
      reqReady_q <= (state_d == ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      virtTarget_q <= 1'b0;
      isWrite_q <= 1'b0;
    end else if (accept) begin
      // operand codes reached through a pointer are never forwarded
      virtTarget_q <= isVirtual(target);
      isWrite_q <= req.write;
    end
  end

  // ----------------------------------------------------------------
  // data RAM port
  // ----------------------------------------------------------------
  // the full pointer value is the address, no banking applies
  always_ff @(posedge clk) begin
    if (reset) begin
      ram_q.en <= 1'b0;
      ram_q.we <= 1'b0;
      ram_q.addr <= PTR_RESET;
      ram_q.wdata <= BYTE_ZERO;
    end else if (accept) begin
      ram_q.en <= !isVirtual(target);
      ram_q.we <= req.write && !isVirtual(target);
      ram_q.addr <= target;
      ram_q.wdata <= req.wdata;
    end else begin
      ram_q.en <= 1'b0;
      ram_q.we <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_q.valid <= 1'b0;
      rsp_q.data <= BYTE_ZERO;
    end else if (state_q == ST_ISSUE && (isWrite_q || virtTarget_q)) begin
      rsp_q.valid <= 1'b1;
      rsp_q.data <= BYTE_ZERO;
    end else if (state_q == ST_WAIT) begin
      rsp_q.valid <= 1'b1;
      rsp_q.data <= ramRdata;
    end else begin
      rsp_q.valid <= 1'b0;
    end
  end

endmodule

// file: bench/iptr_unit_chk.sv
// concurrent checks on the ports of the pointer addressing unit
`timescale 1ns/1ps
module iptr_chk
  import iptr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request side
  input iptr_req_t req,
  input wire logic reqReady_q,
  input iptr_rsp_t rsp_q,
  input iptr_ptrwr_t ptrWr,
  input wire logic [NUM_PAIRS-1:0][PTR_W-1:0] ptrView_q,
  // ram side
  input iptr_ram_t ram_q,
  input wire logic [BYTE_W-1:0] ramRdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  wire take = req.valid && reqReady_q && !ptrWr.valid;
  wire [PTR_W-1:0] cur = ptrView_q[req.pair];
  wire [PTR_W-1:0] incP = cur + PTR_STEP;
  wire [PTR_W-1:0] decP = cur - PTR_STEP;
  wire [PTR_W-1:0] offP = cur + {{HI_USED_W{req.wreg[7]}}, req.wreg};
  // any operand code of any pair counts as a virtual target
  wire virt = (cur <= VOP_BASE0 && cur >= VOP_BASE0 - VOP_SPAN) ||
    (cur <= VOP_BASE1 && cur >= VOP_BASE1 - VOP_SPAN) ||
    (cur <= VOP_BASE2 && cur >= VOP_BASE2 - VOP_SPAN);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  plain_addr_a: assert property (take && req.mode == MODE_PLAIN
    |=> !ram_q.en || ram_q.addr == $past(cur)) else $error("plain target");
  keep_ptr_a: assert property (take && req.mode inside
    {MODE_PLAIN, MODE_OFFSET} |=> $stable(ptrView_q)) else $error("kept");
  post_inc_a: assert property (take && req.mode == MODE_POST_INCREMENT_OPERAND
    |=> ptrView_q[$past(req.pair)] == $past(incP)) else $error("post_increment_operand");
  post_dec_a: assert property (take && req.mode == MODE_POST_DECREMENT_OPERAND
    |=> ptrView_q[$past(req.pair)] == $past(decP)) else $error("post_decrement_operand");
  pre_inc_a: assert property (take && req.mode == MODE_PRE_INCREMENT_OPERAND
    |=> ptrView_q[$past(req.pair)] == $past(incP) &&
    (!ram_q.en || ram_q.addr == $past(incP)))
    else $error("pre_increment_operand target");
  offset_addr_a: assert property (take && req.mode == MODE_OFFSET
    |=> !ram_q.en || ram_q.addr == $past(offP)) else $error("offset");
  virt_zero_a: assert property (take && virt &&
    req.mode inside {MODE_PLAIN, MODE_POST_DECREMENT_OPERAND, MODE_POST_INCREMENT_OPERAND}
    |=> !ram_q.en ##1 rsp_q.valid && rsp_q.data == BYTE_ZERO)
    else $error("virtual access");
  write_data_a: assert property (take && req.write
    |=> !ram_q.en || ram_q.we && ram_q.wdata == $past(req.wdata))
    else $error("write data");
  busy_after_take_a: assert property (take |=> !reqReady_q)
    else $error("ready after take");
  ready_with_answer_a: assert property (rsp_q.valid |-> reqReady_q)
    else $error("ready with answer");
  cover property (take && req.mode == MODE_POST_INCREMENT_OPERAND);
  cover property (take && req.mode == MODE_PRE_INCREMENT_OPERAND);
  cover property (take && req.mode == MODE_OFFSET);
endmodule
bind iptr_unit iptr_chk chk(.clk, .reset, .req, .reqReady_q, .rsp_q, .ptrWr,
  .ptrView_q, .ram_q, .ramRdata);

// file: bench/iptr_ram.sv
// behavioural data ram behind the unit
`timescale 1ns/1ps
module iptr_ram
  import iptr_pkg::*;
(
  input wire logic clk,
  input iptr_ram_t ram,
  output logic [BYTE_W-1:0] rdata
);
  logic [BYTE_W-1:0] mem [0:4095];
  initial rdata = 8'hA5;
  // read data valid only the cycle after a read, else it toggles
  always @(posedge clk) begin
    if (ram.en && ram.we) mem[ram.addr] <= ram.wdata;
    rdata <= (ram.en && !ram.we) ? mem[ram.addr] : ~rdata;
  end
endmodule

// file: bench/test_indirect_pointer_addressing.sv
// self-checking bench of the indirect pointer addressing unit
`timescale 1ns/1ps
module test_indirect_pointer_addressing;
  import iptr_pkg::*;
  logic clk = 0;
  logic reset = 1;
  iptr_req_t req = '0;
  iptr_ptrwr_t ptrWr = '0;
  logic reqReady_q;
  iptr_rsp_t rsp_q;
  logic [NUM_PAIRS-1:0][PTR_W-1:0] ptrView_q;
  iptr_ram_t ram_q;
  logic [BYTE_W-1:0] ramRdata;
  logic [PTR_W-1:0] lastAddr;
  logic [BYTE_W-1:0] d;
  int nRam = 0;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  iptr_unit dut(.clk(clk), .reset(reset), .req(req), .reqReady_q(reqReady_q),
    .rsp_q(rsp_q), .ptrWr(ptrWr), .ptrView_q(ptrView_q), .ram_q(ram_q),
    .ramRdata(ramRdata));
  iptr_ram ram(.clk(clk), .ram(ram_q), .rdata(ramRdata));
  // ram access monitor and hang limit
  always @(posedge clk) begin
    cycles++;
    if (ram_q.en) begin
      lastAddr <= ram_q.addr;
      nRam++;
    end
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(string what, logic [PTR_W-1:0] exp, logic [PTR_W-1:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task setPtr(int p, logic [7:0] hi, logic [7:0] lo);
    @(negedge clk);
    ptrWr = '{1'b1, p[1:0], 1'b1, hi};
    @(negedge clk);
    ptrWr = '{1'b1, p[1:0], 1'b0, lo};
    @(negedge clk);
    ptrWr.valid = 1'b0;
  endtask
  task access(int p, iptr_mode_t m, logic w, logic [7:0] wd, logic [7:0] wr);
    int k;
    k = 0;
    @(negedge clk);
    while (reqReady_q !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    req = '{1'b1, p[1:0], m, w, wd, wr};
    @(negedge clk);
    req.valid = 1'b0;
    while (rsp_q.valid !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    d = rsp_q.data;
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_plain();
    check("reset ptr", 12'h000, ptrView_q[2]);
    setPtr(0, 8'hF1, 8'hFF);
    check("high nibble", 12'h1FF, ptrView_q[0]);
    access(0, MODE_PLAIN, 1'b1, 8'h5A, 8'hC3);
    check("plain addr", 12'h1FF, lastAddr);
    check("plain ptr", 12'h1FF, ptrView_q[0]);
  endtask
  task t_offset();
    setPtr(1, 8'h02, 8'h00);
    access(1, MODE_OFFSET, 1'b0, 8'h00, 8'hFF);
    check("offset data", 8'h5A, d);
    check("offset addr", 12'h1FF, lastAddr);
    access(1, MODE_OFFSET, 1'b1, 8'h11, 8'h7F);
    check("offset plus", 12'h27F, lastAddr);
    check("offset ptr", 12'h200, ptrView_q[1]);
  endtask
  task t_steps();
    setPtr(2, 8'h00, 8'hFF);
    access(2, MODE_POST_INCREMENT_OPERAND, 1'b1, 8'h21, 8'h00);
    check("post_increment_operand addr", 12'h0FF, lastAddr);
    check("post_increment_operand carry", 12'h100, ptrView_q[2]);
    access(2, MODE_POST_DECREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
    check("post_decrement_operand addr", 12'h100, lastAddr);
    access(2, MODE_POST_DECREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
    check("post_decrement_operand data", 8'h21, d);
    check("post_decrement_operand ptr", 12'h0FE, ptrView_q[2]);
    setPtr(2, 8'h0F, 8'hFF);
    access(2, MODE_PRE_INCREMENT_OPERAND, 1'b1, 8'h44, 8'h00);
    check("pre_increment_operand addr", 12'h000, lastAddr);
    check("pre_increment_operand wrap", 12'h000, ptrView_q[2]);
    access(2, MODE_POST_DECREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
    check("read back", 8'h44, d);
    check("dec wrap", 12'hFFF, ptrView_q[2]);
  endtask
  task t_virtual();
    int n0;
    setPtr(0, 8'h0F, 8'hED);
    n0 = nRam;
    access(0, MODE_PLAIN, 1'b1, 8'h77, 8'h00);
    access(0, MODE_PLAIN, 1'b0, 8'h00, 8'h00);
    check("virtual read", 8'h00, d);
    check("virtual ram", n0, nRam);
    // pair one aimed at an operand code of pair zero
    setPtr(1, 8'h0F, 8'hEF);
    access(1, MODE_POST_INCREMENT_OPERAND, 1'b0, 8'h00, 8'h00);
    check("cross read", 8'h00, d);
    check("cross ram", n0, nRam);
    check("cross step", 12'hFF0, ptrView_q[1]);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset = 0;
    t_plain();
    t_offset();
    t_steps();
    t_virtual();
    stop_test();
  end
endmodule
